// file: rtl/plr_regs.sv
// Purpose: control bank for charge pump, LO path and oscillator settings
// Assumes: whole 24-bit words arrive with a one-cycle strobe on clk_i
// Notes:   words with other routing codes pass by untouched
// How it works
// - code 100 loads the charge pump and reference register.
// - code 101 loads the LO path and modulator register.
// - code 110 loads the oscillator control register.
// - source bit low: two bits pick one of four internal currents.
// - source bit high: current scaled from external set resistor.
// - bits 16..12 give the detector phase offset multiplier.
// - bit 17 gives the phase offset sign.
// - reference scaling of double, unity, half or quarter.
// - output multiplexer selects signals, lock detect after reset.
// - bias and output enables for the modulator, output enable gated by bias.
// - select pin low, external bit set, driver clear: port is 2x input.
// - otherwise output, bit 5 picks 1x or 2x, driver bit or select pin high enables it.
// - band source bit picks calibrated or manual band.
// - six-bit amplitude, reset 8, host should write 63.
// - oscillator and charge pump enables, pump enabled at reset.
// - reset words 0x12A7E4, 0x0000E5 and 0x1E2106.
`timescale 1ns/100ps
`include "plr_consts.svh"

// one control word, loaded when its routing code arrives
module plr_word_slot #(
  parameter int                WORD_W   = `PLR_WORD_W,
  parameter logic [2:0]        CODE     = `PLR_CODE_CP,
  parameter logic [WORD_W-1:0] RST_WORD = `PLR_CP_RST
) (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  // serial word in
  input  wire logic              word_valid_i,
  input  wire logic [WORD_W-1:0] word_i,
  // next and stored word, write pulse
  output logic [WORD_W-1:0]      word_next_o,
  output logic [WORD_W-1:0]      word_o,
  output logic                   written_o
);

  if (WORD_W <= `PLR_CODE_MSB) begin : g_width_check
    $error("plr_word_slot: WORD_W too small for the routing code");
  end
  if (RST_WORD[`PLR_CODE_MSB:0] != CODE) begin : g_code_check
    $error("plr_word_slot: reset word must carry its own code");
  end

  typedef struct packed {
    logic [WORD_W-1:0] word;
    logic              written;
  } plr_slot_s;

  localparam plr_slot_s SLOT_RST = '{word: RST_WORD, written: 1'b0};

  plr_slot_s slot_reg;
  plr_slot_s slot_next;

  always_comb begin
    slot_next         = slot_reg;
    slot_next.written = 1'b0;
    if (word_valid_i && (word_i[`PLR_CODE_MSB:0] == CODE)) begin
      slot_next.word    = word_i;
      slot_next.written = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      slot_reg <= SLOT_RST;
    end else begin
      slot_reg <= slot_next;
    end
  end

  assign word_next_o = slot_next.word;
  assign word_o      = slot_reg.word;
  assign written_o   = slot_reg.written;

endmodule : plr_word_slot

module plr_regs #(
  parameter int WORD_W = `PLR_WORD_W
) (
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_n_i,
  // serial word in
  input  wire logic                 word_valid_i,
  input  wire logic [WORD_W-1:0]    word_i,
  // pins and internal sources
  input  wire logic                 lo_port_select_pin_i,
  input  wire logic [5:0]           osc_band_cal_i,
  input  wire plr_pkg::plr_mux_src_s mux_src_i,
  // decoded controls
  output plr_pkg::plr_cp_cfg_s      cp_cfg_o,
  output plr_pkg::plr_lo_cfg_s      lo_cfg_o,
  output plr_pkg::plr_osc_cfg_s     osc_cfg_o,
  output logic                      multiplexer_output_pin_o,
  // stored words
  output logic [WORD_W-1:0]         cp_word_o,
  output logic [WORD_W-1:0]         lo_word_o,
  output logic [WORD_W-1:0]         osc_word_o,
  // write events
  output logic                      cp_written_o,
  output logic                      lo_written_o,
  output logic                      osc_written_o,
  output logic                      word_passed_o
);

  if (WORD_W != `PLR_WORD_W) begin : g_width_check
    $error("plr_regs: WORD_W must be 24");
  end

  // field layout must fit the word
  if (`PLR_CP_REFSC_MSB >= WORD_W || `PLR_OSC_CP_EN >= WORD_W) begin : g_field_check
    $error("plr_regs: a field lies beyond the word");
  end
  if (`PLR_CP_MUXSEL_LSB <= `PLR_CODE_MSB || `PLR_LO_DRV_EN <= `PLR_CODE_MSB ||
      `PLR_OSC_BAND_LSB <= `PLR_CODE_MSB) begin : g_field_code_check
    $error("plr_regs: a field overlaps the routing code");
  end
  if (`PLR_CP_PHASE_LSB <= `PLR_CP_CURR_MSB ||
      `PLR_CP_SRC_EXT <= `PLR_CP_PHASE_NEG) begin : g_cp_order_check
    $error("plr_regs: charge pump fields overlap");
  end
  if (`PLR_OSC_AMP_LSB <= `PLR_OSC_BAND_SRC ||
      `PLR_OSC_EN_LSB <= `PLR_OSC_AMP_MSB) begin : g_osc_order_check
    $error("plr_regs: oscillator fields overlap");
  end

  typedef struct packed {
    logic [1:0]             sel_sync;
    plr_pkg::plr_cp_cfg_s   cp_cfg;
    plr_pkg::plr_lo_cfg_s   lo_cfg;
    plr_pkg::plr_osc_cfg_s  osc_cfg;
    logic                   mux_pin;
    logic                   passed;
  } plr_state_s;

  function automatic plr_pkg::plr_cp_cfg_s decode_cp(
    input logic [`PLR_WORD_W-1:0] w
  );
    plr_pkg::plr_cp_cfg_s c;
    c.cp_current       = plr_pkg::plr_cp_curr_e'(w[`PLR_CP_CURR_MSB:`PLR_CP_CURR_LSB]);
    c.use_set_resistor = w[`PLR_CP_SRC_EXT];
    c.phase_mult       = w[`PLR_CP_PHASE_MSB:`PLR_CP_PHASE_LSB];
    c.phase_negative   = w[`PLR_CP_PHASE_NEG];
    c.ref_scale        = plr_pkg::plr_ref_scale_e'(w[`PLR_CP_REFSC_MSB:`PLR_CP_REFSC_LSB]);
    c.mux_sel          = plr_pkg::plr_mux_sel_e'(w[`PLR_CP_MUXSEL_MSB:`PLR_CP_MUXSEL_LSB]);
    return c;
  endfunction : decode_cp

  function automatic plr_pkg::plr_lo_cfg_s decode_lo(
    input logic [`PLR_WORD_W-1:0] w,
    input logic                   sel_pin
  );
    plr_pkg::plr_lo_cfg_s c;
    logic                 as_input;
    as_input        = !sel_pin && w[`PLR_LO_EXT_IN] && !w[`PLR_LO_DRV_EN];
    c.lo_port_input = as_input;
    c.lo_out_en     = !as_input && (sel_pin || w[`PLR_LO_DRV_EN]);
    c.lo_out_double = !as_input && w[`PLR_LO_DIV_SEL];
    c.mod_bias_en   = w[`PLR_LO_MOD_BIAS];
    c.mod_out_en    = w[`PLR_LO_MOD_BIAS] && w[`PLR_LO_MOD_OUT];
    return c;
  endfunction : decode_lo

  function automatic plr_pkg::plr_osc_cfg_s decode_osc(
    input logic [`PLR_WORD_W-1:0] w,
    input logic [5:0]             cal_band
  );
    plr_pkg::plr_osc_cfg_s c;
    // band from calibration or manual field
    c.band_manual = w[`PLR_OSC_BAND_SRC];
    c.band        = w[`PLR_OSC_BAND_SRC] ? w[`PLR_OSC_BAND_MSB:`PLR_OSC_BAND_LSB]
                                         : cal_band;
    c.amplitude   = w[`PLR_OSC_AMP_MSB:`PLR_OSC_AMP_LSB];
    c.osc_en      = w[`PLR_OSC_EN_MSB:`PLR_OSC_EN_LSB];
    c.cp_en       = w[`PLR_OSC_CP_EN];
    return c;
  endfunction : decode_osc

  function automatic logic pick_mux(
    input plr_pkg::plr_mux_sel_e sel,
    input plr_pkg::plr_mux_src_s src
  );
    logic v;
    v = 1'b0;
    case (sel)
      plr_pkg::PLR_MUX_REFIN: begin
        v = src.refin;
      end
      plr_pkg::PLR_MUX_REFX2: begin
        v = src.refin_x2;
      end
      plr_pkg::PLR_MUX_REFD2: begin
        v = src.refin_div2;
      end
      plr_pkg::PLR_MUX_REFD4: begin
        v = src.refin_div4;
      end
      plr_pkg::PLR_MUX_PTAT: begin
        v = src.ptat_cmp;
      end
      plr_pkg::PLR_MUX_LOCK: begin
        v = src.lock_detect;
      end
      default: begin
        v = 1'b0;
      end
    endcase
    return v;
  endfunction : pick_mux

  localparam logic [`PLR_WORD_W-1:0] CP_RST  = `PLR_CP_RST;
  localparam logic [`PLR_WORD_W-1:0] LO_RST  = `PLR_LO_RST;
  localparam logic [`PLR_WORD_W-1:0] OSC_RST = `PLR_OSC_RST;

  localparam plr_pkg::plr_cp_cfg_s  CP_CFG_RST  = decode_cp(CP_RST);
  localparam plr_pkg::plr_lo_cfg_s  LO_CFG_RST  = decode_lo(LO_RST, 1'b0);
  localparam plr_pkg::plr_osc_cfg_s OSC_CFG_RST = decode_osc(OSC_RST, `PLR_BAND_RST);

  localparam plr_state_s STATE_RST = '{
    sel_sync: 2'h0,
    cp_cfg:   CP_CFG_RST,
    lo_cfg:   LO_CFG_RST,
    osc_cfg:  OSC_CFG_RST,
    mux_pin:  1'b0,
    passed:   1'b0
  };

  plr_state_s        state_reg;
  plr_state_s        state_next;
  logic [2:0]        code;
  logic [WORD_W-1:0] cp_word_next;
  logic [WORD_W-1:0] lo_word_next;
  logic [WORD_W-1:0] osc_word_next;

  assign code = word_i[`PLR_CODE_MSB:0];

  // one slot per routing code
  // charge pump word
  plr_word_slot #(
    .WORD_W  (WORD_W),
    .CODE    (`PLR_CODE_CP),
    .RST_WORD(CP_RST)
  ) i_cp_slot (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .word_valid_i(word_valid_i),
    .word_i      (word_i),
    .word_next_o (cp_word_next),
    .word_o      (cp_word_o),
    .written_o   (cp_written_o)
  );

  plr_word_slot #(
    .WORD_W  (WORD_W),
    .CODE    (`PLR_CODE_LO),
    .RST_WORD(LO_RST)
  ) i_lo_slot (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .word_valid_i(word_valid_i),
    .word_i      (word_i),
    .word_next_o (lo_word_next),
    .word_o      (lo_word_o),
    .written_o   (lo_written_o)
  );

  plr_word_slot #(
    .WORD_W  (WORD_W),
    .CODE    (`PLR_CODE_OSC),
    .RST_WORD(OSC_RST)
  ) i_osc_slot (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .word_valid_i(word_valid_i),
    .word_i      (word_i),
    .word_next_o (osc_word_next),
    .word_o      (osc_word_o),
    .written_o   (osc_written_o)
  );

  always_comb begin
    state_next        = state_reg;
    state_next.passed = 1'b0;
    // select pin through two flops
    state_next.sel_sync[0] = lo_port_select_pin_i;
    state_next.sel_sync[1] = state_reg.sel_sync[0];
    if (word_valid_i) begin
      case (code)
        `PLR_CODE_CP, `PLR_CODE_LO, `PLR_CODE_OSC: begin
          state_next.passed = 1'b0;
        end
        default: begin
          state_next.passed = 1'b1;
        end
      endcase
    end
    state_next.cp_cfg  = decode_cp(cp_word_next);
    state_next.lo_cfg  = decode_lo(lo_word_next, state_reg.sel_sync[1]);
    state_next.osc_cfg = decode_osc(osc_word_next, osc_band_cal_i);
    state_next.mux_pin = pick_mux(state_reg.cp_cfg.mux_sel, mux_src_i);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= STATE_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  assign cp_cfg_o                 = state_reg.cp_cfg;
  assign lo_cfg_o                 = state_reg.lo_cfg;
  assign osc_cfg_o                = state_reg.osc_cfg;
  assign multiplexer_output_pin_o = state_reg.mux_pin;
  assign word_passed_o            = state_reg.passed;

endmodule : plr_regs

// file: rtl/plr_consts.svh
// Purpose: offsets, field positions and reset words of the control bank
// Assumes: 24-bit words, 3-bit routing code in the low bits
// Notes:   definitions only
`ifndef PLR_CONSTS_SVH
`define PLR_CONSTS_SVH
`define PLR_WORD_W          24
`define PLR_CODE_MSB        2
`define PLR_CODE_CP         3'h4
`define PLR_CODE_LO         3'h5
`define PLR_CODE_OSC        3'h6
`define PLR_CP_RST          24'h12A7E4
`define PLR_LO_RST          24'h0000E5
`define PLR_OSC_RST         24'h1E2106
`define PLR_BAND_RST        6'h00
`define PLR_CP_MUXSEL_LSB   6
`define PLR_CP_MUXSEL_MSB   8
`define PLR_CP_CURR_LSB     10
`define PLR_CP_CURR_MSB     11
`define PLR_CP_PHASE_LSB    12
`define PLR_CP_PHASE_MSB    16
`define PLR_CP_PHASE_NEG    17
`define PLR_CP_SRC_EXT      18
`define PLR_CP_REFSC_LSB    21
`define PLR_CP_REFSC_MSB    22
`define PLR_LO_DRV_EN       3
`define PLR_LO_EXT_IN       4
`define PLR_LO_DIV_SEL      5
`define PLR_LO_MOD_BIAS     6
`define PLR_LO_MOD_OUT      7
`define PLR_OSC_BAND_LSB    3
`define PLR_OSC_BAND_MSB    8
`define PLR_OSC_BAND_SRC    9
`define PLR_OSC_AMP_LSB     10
`define PLR_OSC_AMP_MSB     15
`define PLR_OSC_EN_LSB      17
`define PLR_OSC_EN_MSB      19
`define PLR_OSC_CP_EN       20
`endif

// file: rtl/plr_pkg.sv
// Purpose: types of the control bank
// Assumes: field positions in plr_consts.svh
// Notes:   carriers for decoded controls
package plr_pkg;
  typedef enum logic [1:0] {
    PLR_CP_250UA  = 2'h0,
    PLR_CP_500UA  = 2'h1,
    PLR_CP_750UA  = 2'h2,
    PLR_CP_1000UA = 2'h3
  } plr_cp_curr_e;
  typedef enum logic [1:0] {
    PLR_REF_X1    = 2'h0,
    PLR_REF_X2    = 2'h1,
    PLR_REF_DIV2  = 2'h2,
    PLR_REF_DIV4  = 2'h3
  } plr_ref_scale_e;
  typedef enum logic [2:0] {
    PLR_MUX_REFIN = 3'h0,
    PLR_MUX_REFX2 = 3'h1,
    PLR_MUX_REFD2 = 3'h2,
    PLR_MUX_REFD4 = 3'h3,
    PLR_MUX_PTAT  = 3'h4,
    PLR_MUX_RSV5  = 3'h5,
    PLR_MUX_RSV6  = 3'h6,
    PLR_MUX_LOCK  = 3'h7
  } plr_mux_sel_e;
  typedef struct packed {
    plr_cp_curr_e   cp_current;
    logic           use_set_resistor;
    logic [4:0]     phase_mult;
    logic           phase_negative;
    plr_ref_scale_e ref_scale;
    plr_mux_sel_e   mux_sel;
  } plr_cp_cfg_s;
  typedef struct packed {
    logic lo_port_input;
    logic lo_out_en;
    logic lo_out_double;
    logic mod_bias_en;
    logic mod_out_en;
  } plr_lo_cfg_s;
  typedef struct packed {
    logic       band_manual;
    logic [5:0] band;
    logic [5:0] amplitude;
    logic [2:0] osc_en;
    logic       cp_en;
  } plr_osc_cfg_s;
  typedef struct packed {
    logic refin;
    logic refin_x2;
    logic refin_div2;
    logic refin_div4;
    logic ptat_cmp;
    logic lock_detect;
  } plr_mux_src_s;
endpackage : plr_pkg

// file: bench/plr_regs_properties.sv
// Purpose: port checks of the control bank
// Assumes: bound to plr_regs, one clock
// Notes:   word routing and field decode
`timescale 1ns/100ps
module plr_regs_properties (
  // clock and reset
  input wire logic                  clk_i,
  input wire logic                  rst_n_i,
  // serial word in
  input wire logic                  word_valid_i,
  input wire logic [23:0]           word_i,
  // stored words
  input wire logic [23:0]           cp_word_o,
  input wire logic [23:0]           lo_word_o,
  input wire logic [23:0]           osc_word_o,
  // write events
  input wire logic                  cp_written_o,
  input wire logic                  lo_written_o,
  input wire logic                  osc_written_o,
  input wire logic                  word_passed_o,
  // decoded controls
  input wire plr_pkg::plr_cp_cfg_s  cp_cfg_o,
  input wire plr_pkg::plr_lo_cfg_s  lo_cfg_o,
  input wire plr_pkg::plr_osc_cfg_s osc_cfg_o
);
  logic [2:0] c;
  assign c = word_i[2:0];
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_cp_route: assert property (word_valid_i && c == 3'h4 |=>
    cp_written_o && cp_word_o == $past(word_i)) else $error("cp word not stored");
  a_lo_route: assert property (word_valid_i && c == 3'h5 |=>
    lo_written_o && lo_word_o == $past(word_i)) else $error("lo word not stored");
  a_osc_route: assert property (word_valid_i && c == 3'h6 |=>
    osc_written_o && osc_word_o == $past(word_i)) else $error("osc word not stored");
  a_other_kept: assert property (word_valid_i && c != 3'h4 |=>
    $stable(cp_word_o) && !cp_written_o) else $error("cp word changed");
  a_pass_pulse: assert property (word_valid_i && !(c inside {3'h4, 3'h5, 3'h6}) |=>
    word_passed_o) else $error("pass pulse missing");
  a_no_event: assert property (!word_valid_i |=>
    !(cp_written_o | lo_written_o | osc_written_o | word_passed_o)) else $error("stray pulse");
  a_amp_field: assert property (osc_written_o |->
    osc_cfg_o.amplitude == osc_word_o[15:10]) else $error("amplitude wrong");
  a_mod_enables: assert property (lo_written_o |->
    lo_cfg_o.mod_out_en == (lo_word_o[7] & lo_word_o[6])) else $error("modulator enable wrong");
  a_phase_field: assert property (cp_written_o |-> cp_cfg_o.phase_mult == cp_word_o[16:12]
    && cp_cfg_o.phase_negative == cp_word_o[17]) else $error("phase field wrong");
  c_burst: cover property (cp_written_o ##1 lo_written_o);
  c_passed: cover property (word_passed_o);
  c_manual: cover property (osc_written_o && osc_cfg_o.band_manual);
endmodule : plr_regs_properties
bind plr_regs plr_regs_properties i_props (.*);

// file: bench/plr_host_model.sv
// Purpose: host side writing serial words
// Assumes: caller aligned to a rising edge
// Notes:   released word line shows inverse of last word
`timescale 1ns/100ps
module plr_host_model (
  input  wire logic   clk_i,
  output logic        word_valid_o,
  output logic [23:0] word_o
);
  initial begin
    word_valid_o = 1'h0;
    word_o       = 24'h000000;
  end
  task put(input logic [23:0] w);
    word_valid_o <= 1'h1;
    word_o       <= w;
    @(posedge clk_i);
  endtask : put
  task drop();
    word_valid_o <= 1'h0;
    word_o       <= ~word_o;
    @(negedge clk_i);
  endtask : drop
endmodule : plr_host_model

// file: bench/test_pll_lo_vco_control_regs.sv
// Purpose: self-checking bench of the control bank
// Assumes: host model drives words, checks at falling edge
// Notes:   expectations built from field positions
`timescale 1ns/100ps
`include "plr_consts.svh"
module test_pll_lo_vco_control_regs;
  logic                  clk_i = 1'h0, rst_n_i = 1'h0, pin = 1'h0, vld, mux_pin;
  logic [5:0]            cal = 6'h00;
  plr_pkg::plr_mux_src_s src = '0;
  plr_pkg::plr_cp_cfg_s  cp_cfg;
  plr_pkg::plr_lo_cfg_s  lo_cfg;
  plr_pkg::plr_osc_cfg_s osc_cfg;
  logic [23:0]           wd, cpw, low, oscw;
  logic [23:0]           e_cp = `PLR_CP_RST, e_lo = `PLR_LO_RST, e_osc = `PLR_OSC_RST;
  int                    n_errors = 0, total_checks = 0;
  always #2 clk_i = ~clk_i;
  plr_host_model i_host (.clk_i(clk_i), .word_valid_o(vld), .word_o(wd));
  plr_regs i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .word_valid_i(vld), .word_i(wd),
    .lo_port_select_pin_i(pin), .osc_band_cal_i(cal), .mux_src_i(src), .cp_cfg_o(cp_cfg),
    .lo_cfg_o(lo_cfg), .osc_cfg_o(osc_cfg), .multiplexer_output_pin_o(mux_pin),
    .cp_word_o(cpw), .lo_word_o(low), .osc_word_o(oscw), .cp_written_o(),
    .lo_written_o(), .osc_written_o(), .word_passed_o());
  task chk(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  function logic [13:0] cpx(input logic [23:0] r);
    return {r[11:10], r[18], r[16:12], r[17], r[22:21], r[8:6]};
  endfunction : cpx
  task words();
    chk(cpw, e_cp);
    chk(low, e_lo);
    chk(oscw, e_osc);
  endtask : words
  function void note(input logic [23:0] w);
    case (w[2:0])
      3'h4: e_cp = w;
      3'h5: e_lo = w;
      3'h6: e_osc = w;
      default: ;
    endcase
  endfunction : note
  task wr(input logic [23:0] w);
    @(posedge clk_i);
    i_host.put(w);
    i_host.drop();
    note(w);
    words();
  endtask : wr
  task close_out();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out
  task t_reset();
    @(negedge clk_i);
    words();
    chk(24'(cp_cfg), 24'(cpx(`PLR_CP_RST)));
    chk(24'({osc_cfg.amplitude, osc_cfg.osc_en, osc_cfg.cp_en}), 24'h00008F);
    $display("reset done");
  endtask : t_reset
  task t_route();
    for (int c = 0; c < 8; c++) wr({5'h15, c[2:0], 13'h1E3C, c[2:0]});
    @(posedge clk_i);
    i_host.put(24'h0A5E14);
    i_host.put(24'h0000C5);
    i_host.put(24'h1FFC0E);
    i_host.put(24'h5A5A57);
    i_host.drop();
    note(24'h0A5E14);
    note(24'h0000C5);
    note(24'h1FFC0E);
    words();
    $display("route done");
  endtask : t_route
  task t_cp();
    logic [23:0] w;
    for (int i = 0; i < 4; i++) begin
      w = {1'h0, i[1:0], 2'h0, i[0], i[1], 5'h06, i[1:0], 1'h0, 3'h7, 6'h04};
      wr(w);
      chk(24'(cp_cfg), 24'(cpx(w)));
    end
    for (int k = 0; k < 16; k++) begin
      @(posedge clk_i);
      src <= k[3] ? 6'h16 : 6'h29;
      wr({7'h00, 5'h06, 3'h0, k[2:0], 6'h04});
      @(negedge clk_i);
      chk(24'(mux_pin), 24'(((k[3] ? 8'h1A : 8'h85) >> k[2:0]) & 8'h01));
    end
    $display("cp done");
  endtask : t_cp
  task t_lo();
    logic inp;
    for (int k = 0; k < 64; k++) begin
      @(posedge clk_i);
      pin <= k[5];
      wr({16'h0000, k[4:0], 3'h5});
      repeat (2) @(negedge clk_i);
      inp = ~k[5] & k[1] & ~k[0];
      chk(24'(lo_cfg), 24'({inp, k[5] | k[0], k[2] & ~inp, k[3], k[3] & k[4]}));
    end
    $display("lo done");
  endtask : t_lo
  task t_osc();
    @(posedge clk_i);
    cal <= 6'h2B;
    for (int j = 0; j < 2; j++) begin
      wr({3'h0, {4{j[0]}}, 1'h0, 6'h3F, j[0], 6'h15, 3'h6});
      chk(24'(osc_cfg), 24'({j[0], j[0] ? 6'h15 : 6'h2B, 6'h3F, {4{j[0]}}}));
    end
    $display("osc done");
  endtask : t_osc
  initial begin
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'h1;
    t_reset();
    t_route();
    t_cp();
    t_lo();
    t_osc();
    close_out();
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    n_errors++;
    close_out();
  end
endmodule : test_pll_lo_vco_control_regs
